// *** coherent_storage_ordering_pkg.sv ***
// shared constants, types and decode helpers for the coherence unit
package coherent_storage_ordering_pkg;

   // ************************************************************
   // widths and geometry
   // ************************************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int BE_W = 8;
   localparam int PAGE_LSB = 12;
   localparam int PAGE_W = ADDR_W - PAGE_LSB;
   localparam int BLOCK_LSB = 5;
   localparam int LINE_W = ADDR_W - BLOCK_LSB;
   localparam int TRACK_DEPTH = 4;
   localparam int TRACK_IDX_W = 2;
   localparam logic DWORD_ATOMIC = 1'b1;

   // ************************************************************
   // access sizes, barriers and page_storage_attrs bits
   // ************************************************************
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_DWORD = 2'h3;
   localparam logic [1:0] BAR_NONE = 2'h0;
   localparam logic [1:0] BAR_IO_ORDER = 2'h1;
   localparam logic [1:0] BAR_SYNC = 2'h2;
   localparam logic [1:0] BAR_ISYNC = 2'h3;
   localparam int ATTR_W = 2;
   localparam int ATTR_I = 1;
   localparam int ATTR_M = 0;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_MEM_LIMIT = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_COUNT = 12'h00C;
   localparam int CTRL_COH_EN = 0;
   localparam logic CTRL_COH_EN_RESET = 1'b1;
   localparam logic [19:0] MEM_LIMIT_RESET = 20'h0_0800;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_INVAL = 7'h02,
      ST_SNOOP = 7'h04,
      ST_PREP = 7'h08,
      ST_ISSUE = 7'h10,
      ST_WAIT = 7'h20,
      ST_DONE = 7'h40
   } state_t;

   // byte lanes touched by an aligned access of the given size
   function automatic logic [7:0] size_be(input logic [1:0] size);
      unique case (size)
         SIZE_BYTE: size_be = 8'h01;
         SIZE_HALF: size_be = 8'h03;
         SIZE_WORD: size_be = 8'h0F;
         SIZE_DWORD: size_be = 8'hFF;
      endcase
   endfunction

endpackage

// *** access_splitter.sv ***
// splits one access into single-copy atomic memory pieces
`timescale 1ns/1ns
module access_splitter
   import coherent_storage_ordering_pkg::*;
(
   input wire logic [2:0] off,
   input wire logic [1:0] size,
   input wire logic [2:0] piece,
   output logic aligned,
   output logic [3:0] npieces,
   output logic [2:0] lane,
   output logic [7:0] be
);
   import coherent_storage_ordering_pkg::*;

   logic [7:0] lanes;
   logic [2:0] low_mask;

   always_comb begin
      lanes = size_be(size);
      low_mask = {lanes[7], lanes[3], lanes[1]};
      // natural alignment gives one indivisible beat
      aligned = ((off & low_mask) == 3'h0) &&
                ((size != SIZE_DWORD) || DWORD_ATOMIC);
      // anything else goes out byte by byte, no atomicity promised
      npieces = aligned ? 4'h1 : (4'h1 << size);
      lane = aligned ? off : 3'(off + piece);
      be = aligned ? 8'(lanes << off) : 8'(8'h01 << lane);
   end
endmodule // access_splitter

// *** ifetch_line_tracker.sv ***
// remembers lines fetched non-coherently by instruction fetch
`timescale 1ns/1ns
module ifetch_line_tracker
   import coherent_storage_ordering_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic insert_valid,
   input wire logic [LINE_W-1:0] insert_line,
   input wire logic [LINE_W-1:0] lookup_line,
   output logic hit,
   output logic [TRACK_IDX_W-1:0] hit_idx,
   input wire logic clear_valid,
   input wire logic [TRACK_IDX_W-1:0] clear_idx,
   output logic [TRACK_DEPTH-1:0] occupied
);
   import coherent_storage_ordering_pkg::*;

   typedef struct packed {
      logic [TRACK_DEPTH-1:0] valid;
      logic [TRACK_DEPTH-1:0][LINE_W-1:0] line;
      logic [TRACK_IDX_W-1:0] victim;
   } track_state_t;

   track_state_t st;
   track_state_t next_st;
   logic [TRACK_DEPTH-1:0] match;
   logic [TRACK_DEPTH-1:0] ins_match;

   genvar g;
   generate
      for (g = 0; g < TRACK_DEPTH; g++) begin : g_cmp
         assign match[g] = st.valid[g] && (st.line[g] == lookup_line);
         assign ins_match[g] = st.valid[g] && (st.line[g] == insert_line);
      end
   endgenerate

   always_comb begin
      next_st = st;
      hit = |match;
      hit_idx = '0;
      for (int i = 0; i < TRACK_DEPTH; i++) begin
         if (match[i]) begin
            hit_idx = TRACK_IDX_W'(i);
         end
      end
      if (insert_valid && !(|ins_match)) begin
         // round-robin replacement: losing an entry only costs a refetch
         next_st.valid[st.victim] = 1'b1;
         next_st.line[st.victim] = insert_line;
         next_st.victim = TRACK_IDX_W'(st.victim + 1'b1);
      end
      if (clear_valid) begin
         next_st.valid[clear_idx] = 1'b0;
      end
      occupied = st.valid;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   chk_clear_drops_entry: assert property (@(posedge core_clk)
      disable iff (!rst_n) clear_valid |=> !st.valid[$past(clear_idx)])
      else $error("cleared tracker entry still valid");
endmodule // ifetch_line_tracker

// *** coherent_storage_ordering.sv ***
// coherence and storage-ordering unit between cpu, host bridge and memory
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module coherent_storage_ordering
   import coherent_storage_ordering_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_req_valid,
   output logic cpu_req_ready,
   input wire logic cpu_req_write,
   input wire logic cpu_req_ifetch,
   input wire logic [1:0] cpu_req_barrier,
   input wire logic [ATTR_W:0] page_storage_attrs,
   input wire logic [1:0] cpu_req_size,
   input wire logic [ADDR_W-1:0] cpu_req_addr,
   input wire logic [DATA_W-1:0] cpu_req_wdata,
   output logic cpu_rsp_valid,
   output logic [DATA_W-1:0] cpu_rsp_rdata,
   input wire logic io_req_valid,
   output logic io_req_ready,
   input wire logic io_req_write,
   input wire logic [1:0] io_req_size,
   input wire logic [ADDR_W-1:0] io_req_addr,
   input wire logic [DATA_W-1:0] io_req_wdata,
   output logic io_rsp_valid,
   output logic [DATA_W-1:0] io_rsp_rdata,
   output logic mem_req_valid,
   input wire logic mem_req_ready,
   output logic mem_req_write,
   output logic mem_req_coherent,
   output logic [ADDR_W-1:0] mem_req_addr,
   output logic [BE_W-1:0] mem_req_be,
   output logic [DATA_W-1:0] mem_req_wdata,
   input wire logic mem_rsp_valid,
   input wire logic [DATA_W-1:0] mem_rsp_rdata,
   output logic snoop_valid,
   output logic [ADDR_W-1:0] snoop_addr,
   input wire logic snoop_done,
   input wire logic snoop_hit_modified,
   output logic inval_valid,
   output logic [ADDR_W-1:0] inval_addr,
   input wire logic inval_done
);
   import coherent_storage_ordering_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      state_t state;
      logic last_io;
      logic is_io;
      logic write;
      logic ifetch;
      logic [1:0] barrier;
      logic [ATTR_W:0] attrs;
      logic [1:0] size;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic coherent;
      logic in_sys;
      logic [2:0] piece;
      logic [ADDR_W-1:0] mem_addr;
      logic [DATA_W-1:0] mem_wdata;
      logic [BE_W-1:0] mem_be;
      logic [DATA_W-1:0] rdata;
      logic coh_en;
      logic [PAGE_W-1:0] mem_limit;
      logic [15:0] retries;
      logic [15:0] splits;
      logic [31:0] prdata;
   } core_state_t;

   core_state_t st;
   core_state_t next_st;

   function automatic logic in_sysmem(input logic [ADDR_W-1:0] a,
                                      input logic [PAGE_W-1:0] lim);
      in_sysmem = a[ADDR_W-1:PAGE_LSB] < lim;
   endfunction

   logic grant_io;
   logic grant_cpu;
   logic [ADDR_W-1:0] sel_addr;
   logic sel_sys;
   logic sel_coh;
   logic aligned;
   logic [3:0] npieces;
   logic [2:0] lane;
   logic [7:0] be;
   logic last_piece;
   logic [ADDR_W-1:0] piece_addr;
   logic [DATA_W-1:0] lane_mask;
   logic trk_hit;
   logic [TRACK_IDX_W-1:0] trk_idx;
   logic [TRACK_DEPTH-1:0] trk_occ;
   logic trk_insert;
   logic [LINE_W-1:0] trk_lookup;
   logic apb_setup;
   logic apb_write;
   logic mapped;

   access_splitter u_splitter (
      .off(st.addr[2:0]),
      .size(st.size),
      .piece(st.piece),
      .aligned(aligned),
      .npieces(npieces),
      .lane(lane),
      .be(be)
   );

   ifetch_line_tracker u_tracker (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .insert_valid(trk_insert),
      .insert_line(st.addr[ADDR_W-1:BLOCK_LSB]),
      .lookup_line(trk_lookup),
      .hit(trk_hit),
      .hit_idx(trk_idx),
      .clear_valid(inval_valid && inval_done),
      .clear_idx(trk_idx),
      .occupied(trk_occ)
   );

   // ************************************************************
   // arbitration and classification
   // ************************************************************
   always_comb begin
      // alternate priority so neither port starves the other
      grant_io = io_req_valid && (!cpu_req_valid || !st.last_io);
      grant_cpu = cpu_req_valid && !grant_io;
      sel_addr = grant_io ? io_req_addr : cpu_req_addr;
      sel_sys = in_sysmem(sel_addr, st.mem_limit);
      // host bridge traffic to system memory is coherent whenever coh_en is set
      sel_coh = st.coh_en && sel_sys &&
                (grant_io || (page_storage_attrs[ATTR_M] &&
                 !page_storage_attrs[ATTR_I] && !cpu_req_ifetch));
      trk_lookup = (st.state == ST_IDLE) ? sel_addr[ADDR_W-1:BLOCK_LSB]
                                         : st.addr[ADDR_W-1:BLOCK_LSB];
      piece_addr = st.addr + {29'h0, st.piece};
      last_piece = ({1'b0, st.piece} + 4'h1) == npieces;
      for (int i = 0; i < BE_W; i++) begin
         lane_mask[8*i +: 8] = {8{i < (1 << st.size)}};
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      next_st = st;
      apb_setup = psel && !penable;
      apb_write = psel && penable && pwrite;
      mapped = (paddr == REG_CTRL) || (paddr == REG_MEM_LIMIT) ||
               (paddr == REG_STATUS) || (paddr == REG_COUNT);
      unique case (st.state)
         ST_IDLE: begin
            if (grant_io || grant_cpu) begin
               next_st.last_io = grant_io;
               next_st.is_io = grant_io;
               next_st.write = grant_io ? io_req_write : cpu_req_write;
               next_st.ifetch = !grant_io && cpu_req_ifetch;
               next_st.barrier = grant_io ? BAR_NONE : cpu_req_barrier;
               next_st.attrs = page_storage_attrs;
               next_st.size = grant_io ? io_req_size : cpu_req_size;
               next_st.addr = sel_addr;
               next_st.wdata = grant_io ? io_req_wdata : cpu_req_wdata;
               next_st.coherent = sel_coh;
               next_st.in_sys = sel_sys;
               next_st.piece = 3'h0;
               next_st.rdata = '0;
               if (grant_cpu && cpu_req_barrier != BAR_NONE) begin
                  // nothing is ever in flight here, so the barrier is met
                  next_st.state = ST_DONE;
               end else if (grant_cpu && sel_coh && trk_hit) begin
                  next_st.state = ST_INVAL;
               end else if (grant_io && sel_coh) begin
                  next_st.state = ST_SNOOP;
               end else begin
                  next_st.state = ST_PREP;
               end
            end
         end
         ST_INVAL: begin
            if (inval_done) begin
               next_st.state = ST_PREP;
            end
         end
         ST_SNOOP: begin
            if (snoop_done && !snoop_hit_modified) begin
               next_st.state = ST_PREP;
            end else if (snoop_done) begin
               // a modified copy was pushed out; ask again until clean
               next_st.retries = st.retries + 16'h0001;
            end
         end
         ST_PREP: begin
            next_st.mem_addr = {piece_addr[ADDR_W-1:3], 3'h0};
            next_st.mem_be = be;
            if (aligned) begin
               next_st.mem_wdata = st.wdata << {st.addr[2:0], 3'h0};
            end else begin
               next_st.mem_wdata = {56'h0, st.wdata[{st.piece, 3'h0} +: 8]}
                                   << {lane, 3'h0};
            end
            next_st.state = ST_ISSUE;
         end
         ST_ISSUE: begin
            if (mem_req_ready) begin
               next_st.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (mem_rsp_valid) begin
               if (aligned) begin
                  next_st.rdata = (mem_rsp_rdata >> {st.addr[2:0], 3'h0})
                                  & lane_mask;
               end else begin
                  next_st.rdata[{st.piece, 3'h0} +: 8] =
                     mem_rsp_rdata[{lane, 3'h0} +: 8];
               end
               if (last_piece) begin
                  next_st.state = ST_DONE;
                  if (!aligned) begin
                     next_st.splits = st.splits + 16'h0001;
                  end
               end else begin
                  next_st.piece = 3'(st.piece + 1'b1);
                  next_st.state = ST_PREP;
               end
            end
         end
         ST_DONE: begin
            next_st.state = ST_IDLE;
         end
      endcase
      // ************************************************************
      // apb registers, zero wait states
      // ************************************************************
      if (apb_setup) begin
         unique case (paddr)
            REG_CTRL: next_st.prdata = {31'h0, st.coh_en};
            REG_MEM_LIMIT: next_st.prdata = {12'h000, st.mem_limit};
            REG_STATUS: next_st.prdata = {21'h0, trk_occ, st.state};
            REG_COUNT: next_st.prdata = {st.splits, st.retries};
            default: next_st.prdata = 32'h0000_0000;
         endcase
      end
      if (apb_write && paddr == REG_CTRL) begin
         next_st.coh_en = pwdata[CTRL_COH_EN];
      end
      if (apb_write && paddr == REG_MEM_LIMIT) begin
         next_st.mem_limit = pwdata[PAGE_W-1:0];
      end
      if (apb_write && paddr == REG_COUNT) begin
         // a tick in the clearing cycle survives the clear
         next_st.retries = next_st.retries - st.retries;
         next_st.splits = next_st.splits - st.splits;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.state <= ST_IDLE;
         st.coh_en <= CTRL_COH_EN_RESET;
         st.mem_limit <= MEM_LIMIT_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign cpu_req_ready = (st.state == ST_IDLE) && grant_cpu;
   assign io_req_ready = (st.state == ST_IDLE) && grant_io;
   assign cpu_rsp_valid = (st.state == ST_DONE) && !st.is_io;
   assign io_rsp_valid = (st.state == ST_DONE) && st.is_io;
   assign cpu_rsp_rdata = st.rdata;
   assign io_rsp_rdata = st.rdata;
   // memory only ever sees values that reach it, never cache-held ones
   assign mem_req_valid = (st.state == ST_ISSUE);
   assign mem_req_write = st.write;
   assign mem_req_coherent = st.coherent;
   assign mem_req_addr = st.mem_addr;
   assign mem_req_be = st.mem_be;
   assign mem_req_wdata = st.mem_wdata;
   assign snoop_valid = (st.state == ST_SNOOP);
   assign snoop_addr = {st.addr[ADDR_W-1:BLOCK_LSB], 5'h00};
   assign inval_valid = (st.state == ST_INVAL);
   assign inval_addr = {st.addr[ADDR_W-1:BLOCK_LSB], 5'h00};
   assign trk_insert = (st.state == ST_DONE) && st.ifetch && !st.write &&
                       st.in_sys && st.attrs[ATTR_M];
   assign prdata = st.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ************************************************************
   // checks
   // ************************************************************
   chk_atomic_one_beat: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (st.state == ST_WAIT && mem_rsp_valid && aligned) |=>
         st.state == ST_DONE)
      else $error("aligned access took more than one beat");
   chk_split_byte_count: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (mem_req_valid && !aligned) |-> $onehot(mem_req_be))
      else $error("misaligned piece touches more than one byte");
   chk_one_outstanding: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (mem_req_valid && mem_req_ready) |=> !mem_req_valid [*2])
      else $error("second memory request while one outstanding");
   chk_snoop_block_addr: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      snoop_valid |-> snoop_addr[BLOCK_LSB-1:0] == '0)
      else $error("snoop address not block aligned");
   chk_io_coherent_attr: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (mem_req_valid && st.is_io && st.in_sys && st.coh_en) |->
         mem_req_coherent)
      else $error("io access to system memory not coherent");
   chk_exempt_no_snoop: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      snoop_valid |-> st.in_sys)
      else $error("snoop for memory outside system memory");
   chk_modified_retries: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (snoop_done && snoop_valid && snoop_hit_modified) |=>
         snoop_valid && !mem_req_valid)
      else $error("io write proceeded past a modified copy");
   chk_inval_precedes: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (inval_valid && inval_done) |=> st.state == ST_PREP ##1 mem_req_valid)
      else $error("coherent refetch did not follow invalidate");
   chk_rsp_pulse_order: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      cpu_rsp_valid |=> !cpu_rsp_valid && st.state == ST_IDLE)
      else $error("cpu response not a single pulse");
   chk_barrier_drained: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (cpu_rsp_valid && st.barrier != BAR_NONE) |->
         $past(st.state) == ST_IDLE)
      else $error("barrier completed with access in flight");
endmodule // coherent_storage_ordering

// *** coherence_far_model.sv ***
// far-side model: memory, snoop and invalidate responders
`timescale 1ns/1ns
module coherence_far_model
   import coherent_storage_ordering_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic dirty_once,
   input wire logic mem_req_valid,
   output logic mem_req_ready,
   input wire logic [ADDR_W-1:0] mem_req_addr,
   output logic mem_rsp_valid,
   output logic [DATA_W-1:0] mem_rsp_rdata,
   input wire logic snoop_valid,
   output logic snoop_done,
   output logic snoop_hit_modified,
   input wire logic inval_valid,
   output logic inval_done
);
   logic busy;
   logic seen;
   logic [DATA_W-1:0] data;
   // released data lines show the inverse, never a stale copy
   assign mem_rsp_rdata = mem_rsp_valid ? data : ~data;
   // a modified copy answers once, then is written back
   assign snoop_hit_modified = snoop_done & dirty_once & ~seen;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req_ready <= 1'b0;
         mem_rsp_valid <= 1'b0;
         busy <= 1'b0;
         data <= '0;
         snoop_done <= 1'b0;
         seen <= 1'b0;
         inval_done <= 1'b0;
      end else begin
         // one stall cycle before accepting, one request outstanding
         mem_req_ready <= mem_req_valid & ~mem_req_ready & ~busy;
         if (mem_req_valid & mem_req_ready) begin
            data <= {mem_req_addr, mem_req_addr};
         end
         busy <= (busy & ~mem_rsp_valid) | (mem_req_valid & mem_req_ready);
         mem_rsp_valid <= busy & ~mem_rsp_valid;
         snoop_done <= snoop_valid & ~snoop_done;
         seen <= snoop_valid & (seen | snoop_done);
         inval_done <= inval_valid & ~inval_done;
      end
   end
endmodule // coherence_far_model

// *** coherent_storage_ordering_tb.sv ***
// self-checking bench for the coherence and ordering unit
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", n, e, g); \
   end \
end
module coherent_storage_ordering_tb;
   import coherent_storage_ordering_pkg::*;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd32;
   logic pready, pslverr, err, dirty_once = 0;
   logic cpu_req_valid = 0, cpu_req_write = 0, cpu_req_ifetch = 0;
   logic [1:0] cpu_req_barrier = 0, cpu_req_size = 0, io_req_size = 0;
   logic [2:0] page_storage_attrs = 0;
   logic [31:0] cpu_req_addr = 0, io_req_addr = 0, mem_req_addr;
   logic [63:0] cpu_req_wdata = 64'h1122_3344_5566_7788, rd64;
   logic [63:0] io_req_wdata = 64'h99AA_BBCC_DDEE_FF00;
   logic io_req_valid = 0, io_req_write = 0, cpu_req_ready, io_req_ready;
   logic cpu_rsp_valid, io_rsp_valid, mem_req_valid, mem_req_ready;
   logic [63:0] cpu_rsp_rdata, io_rsp_rdata, mem_req_wdata, mem_rsp_rdata;
   logic mem_req_write, mem_req_coherent, mem_rsp_valid, m_coh;
   logic [7:0] mem_req_be, m_be;
   logic [31:0] snoop_addr, inval_addr, m_addr, s_addr;
   logic snoop_valid, snoop_done, snoop_hit_modified;
   logic inval_valid, inval_done;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   int beats, snoops, invals;

   coherent_storage_ordering coherent_storage_ordering_inst (.*);
   coherence_far_model coherence_far_model_inst (.*);

   always #4 core_clk = ~core_clk;

   // ************************************************************
   // monitor and timeout
   // ************************************************************
   always @(posedge core_clk) begin
      if (mem_req_valid && mem_req_ready) begin
         beats++;
         m_addr = mem_req_addr;
         m_be = mem_req_be;
         m_coh = mem_req_coherent;
      end
      if (snoop_valid && snoop_done) begin
         snoops++;
         s_addr = snoop_addr;
      end
      if (inval_valid && inval_done) invals++;
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         results();
      end
   end

   // ************************************************************
   // bus tasks
   // ************************************************************
   task automatic apb(input logic w, input logic [11:0] a);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd32 = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic xfer(input bit io, input logic w, f,
         input logic [1:0] b, s, input logic [2:0] at, input logic [31:0] a);
      beats = 0;
      snoops = 0;
      invals = 0;
      cpu_req_write <= w;
      io_req_write <= w;
      cpu_req_ifetch <= f;
      cpu_req_barrier <= b;
      page_storage_attrs <= at;
      cpu_req_size <= s;
      io_req_size <= s;
      cpu_req_addr <= a;
      io_req_addr <= a;
      if (io) io_req_valid <= 1'b1;
      else cpu_req_valid <= 1'b1;
      do @(posedge core_clk);
      while ((io ? io_req_ready : cpu_req_ready) !== 1'b1);
      cpu_req_valid <= 1'b0;
      io_req_valid <= 1'b0;
      do @(posedge core_clk);
      while ((io ? io_rsp_valid : cpu_rsp_valid) !== 1'b1);
      rd64 = io ? io_rsp_rdata : cpu_rsp_rdata;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic reg_reset;
      apb(1'b0, REG_CTRL);
      `CHK("coh_en", 32'h0000_0001, rd32)
      apb(1'b0, REG_MEM_LIMIT);
      `CHK("mem limit", 32'h0000_0800, rd32)
      apb(1'b1, REG_STATUS);
      apb(1'b0, REG_STATUS);
      `CHK("status idle", 32'h0000_0001, rd32)
      apb(1'b0, 12'h010);
      `CHK("unmapped err", 1'b1, err)
   endtask

   task automatic aligned_read;
      xfer(0, 1'b0, 1'b0, BAR_NONE, SIZE_WORD, 3'b001, 32'h0000_0104);
      `CHK("aligned beats", 1, beats)
      `CHK("aligned addr", 32'h0000_0100, m_addr)
      `CHK("aligned be", 8'hF0, m_be)
      `CHK("page coherent", 1'b1, m_coh)
      `CHK("read data", 64'h0000_0000_0000_0100, rd64)
   endtask

   task automatic split_write;
      xfer(0, 1'b1, 1'b0, BAR_NONE, SIZE_HALF, 3'b001, 32'h0000_0107);
      `CHK("split beats", 2, beats)
      `CHK("split addr", 32'h0000_0108, m_addr)
      `CHK("split be", 8'h01, m_be)
   endtask

   task automatic io_writes;
      dirty_once <= 1'b1;
      xfer(1, 1'b1, 1'b0, BAR_NONE, SIZE_WORD, 3'b000, 32'h0000_021C);
      `CHK("snoop retries", 2, snoops)
      `CHK("snoop block", 32'h0000_0200, s_addr)
      `CHK("io coherent", 1'b1, m_coh)
      `CHK("io beats", 1, beats)
      apb(1'b0, REG_COUNT);
      `CHK("counters", 32'h0001_0001, rd32)
      apb(1'b1, REG_COUNT);
      apb(1'b0, REG_COUNT);
      `CHK("counters clear", 32'h0000_0000, rd32)
      dirty_once <= 1'b0;
      xfer(1, 1'b1, 1'b0, BAR_NONE, SIZE_WORD, 3'b000, 32'h0080_0000);
      `CHK("exempt coherent", 1'b0, m_coh)
      `CHK("exempt snoops", 0, snoops)
   endtask

   task automatic ifetch_refetch;
      xfer(0, 1'b0, 1'b1, BAR_NONE, SIZE_WORD, 3'b001, 32'h0000_0300);
      `CHK("ifetch coherent", 1'b0, m_coh)
      xfer(0, 1'b0, 1'b0, BAR_NONE, SIZE_WORD, 3'b001, 32'h0000_0300);
      `CHK("discard", 1, invals)
      `CHK("refetch coherent", 1'b1, m_coh)
      xfer(0, 1'b0, 1'b0, BAR_NONE, SIZE_WORD, 3'b011, 32'h0000_0300);
      `CHK("aliased coherent", 1'b0, m_coh)
   endtask

   task automatic barriers;
      for (int b = 1; b < 4; b++) begin
         xfer(0, 1'b0, 1'b0, b[1:0], SIZE_BYTE, 3'b001, 32'h0000_0000);
         `CHK("barrier beats", 0, beats)
      end
   endtask

   task automatic results;
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      reg_reset();
      aligned_read();
      split_write();
      io_writes();
      ifetch_refetch();
      barriers();
      results();
   end
endmodule // coherent_storage_ordering_tb
